// *** rtl/led_pwm_pkg.sv ***
// constants shared by the port, blink and pwm logic
// assumes a 100 MHz system clock and an 8-bit register port
package led_pwm_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] ADDR_INPUT = 8'h00;
   localparam logic [7:0] ADDR_PHASE0 = 8'h01;
   localparam logic [7:0] ADDR_DIR = 8'h03;
   localparam logic [7:0] ADDR_PHASE1 = 8'h09;
   localparam logic [7:0] ADDR_MASTER = 8'h0E;
   localparam logic [7:0] ADDR_CONFIG = 8'h0F;
   localparam logic [7:0] ADDR_INTENS0 = 8'h10;
   localparam logic [7:0] ADDR_INTENS3 = 8'h13;

   // ****************************************
   // configuration register fields
   // ****************************************
   localparam int CFG_BLINK_EN = 0;
   localparam int CFG_FLIP = 1;
   localparam int CFG_GLOBAL = 2;
   localparam int CFG_IRQ_EN = 3;
   localparam int CFG_GPO0 = 4;
   localparam int CFG_GPO1 = 5;
   localparam int CFG_ZERO = 6;
   localparam int CFG_STATUS = 7;

   // ****************************************
   // values after reset
   // ****************************************
   localparam logic [7:0] RST_PHASE = 8'hFF;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_MASTER = 8'h0F;
   localparam logic [5:0] RST_CONFIG = 6'h0C;
   localparam logic [3:0] RST_INTENS = 4'hF;

   // ****************************************
   // pwm timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int OSC_PERIOD_NS = 31250;
   // longest time, so round down
   localparam int OSC_TICK_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 12;
   localparam logic [3:0] PWM_LAST_CYCLE = 4'hF;
   localparam logic [3:0] PWM_LAST_SLOT = 4'hE;
   localparam logic [3:0] INTENS_STATIC = 4'hF;

endpackage : led_pwm_pkg

// *** rtl/pwm_timebase.sv ***
// pwm time base: 32 kHz step enable, 16 cycles per slot, 15 slots
// assumes run drops whenever pwm is switched off entirely
`timescale 1ns/1ps
module pwm_timebase (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run,
   output logic [3:0] cycle_idx,
   output logic [3:0] slot_idx
);

   typedef struct packed {
      logic [led_pwm_pkg::TICK_W-1:0] pre;
      logic [3:0] cycle;
      logic [3:0] slot;
   } tb_state_s;

   tb_state_s st_reg;
   tb_state_s st_next;

   always_comb begin
      st_next = st_reg;
      if (!run) begin
         // oscillator stopped: counters parked at the period start
         st_next = '0;
      end else if (st_reg.pre == led_pwm_pkg::TICK_W'(led_pwm_pkg::OSC_TICK_CYCLES - 1)) begin
         st_next.pre = '0;
         st_next.cycle = st_reg.cycle + 4'h1;
         if (st_reg.cycle == led_pwm_pkg::PWM_LAST_CYCLE) begin // [R11]
            st_next.slot = (st_reg.slot == led_pwm_pkg::PWM_LAST_SLOT) ? 4'h0
                                                                     : st_reg.slot + 4'h1;
         end
      end else begin
         st_next.pre = st_reg.pre + led_pwm_pkg::TICK_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cycle_idx = st_reg.cycle;
   assign slot_idx = st_reg.slot;

endmodule : pwm_timebase

// *** rtl/led_port_blink_pwm_control.sv ***
// eight open-drain ports plus the shared ninth pin, with blink and pwm
// assumes a decoded register port from the serial front end and a
// change-detect pulse from the input transition logic
//
// Function
// R1 - irq enable: ninth pin follows change detect
// R2 - no blink: phase-0 gpo bit sets pin
// R3 - blink: pin follows gpo bit of phase
// R4 - config bit 7 reads change status
// R5 - config bit 6 always reads zero
// R6 - blink flags choose phase register for ports
// R7 - output port: 1 hi-z, 0 driven low
// R8 - phase registers read stored value
// R9 - direction 1 input, 0 output, readable
// R10 - 32 kHz time base, stopped when off
// R11 - 240 steps: 15 slots of 16
// R12 - master gates 1 to 15 slots
// R13 - individual duty 1/16..16/16 inside gated slots
// R14 - setting 16/16 gives static output
// R15 - phase-0 bit is on-time level
// R16 - blink: each phase bit is on-level
// R17 - global flag: ninth nibble for all
// R18 - host uses individual control for mixes
// R19 - global: ports use master register low nibble
// R20 - master nibble zero: all outputs static
// R21 - n/16 on cycles in gated slots
`timescale 1ns/1ps
module led_port_blink_pwm_control (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic change_event,
   input wire logic [7:0] pin_sense_bits,
   output logic [7:0] io_ports_out,
   output logic [7:0] io_ports_oe,
   output logic irq_or_gpo_pin_out,
   output logic irq_or_gpo_pin_oe
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [7:0] phase0;
      logic [7:0] phase1;
      logic [7:0] dir;
      logic [7:0] master;
      logic [5:0] cfg;
      logic status;
      logic [7:0][3:0] intens;
      logic [7:0] rdata;
      logic [7:0] ports_oe;
      logic gpo_oe;
   } ctl_state_s;

   ctl_state_s st_reg;
   ctl_state_s st_next;

   logic [3:0] cycle_idx;
   logic [3:0] slot_idx;
   logic pwm_run;

   // ****************************************
   // helpers
   // ****************************************
   // 1 = pull the pin low for this step; lvl is the on-time level
   function automatic logic drive_low(input logic lvl, input logic [3:0] inten,
                                      input logic [3:0] mst, input logic [3:0] cyc,
                                      input logic [3:0] slot);
      logic on_time;
      on_time = 1'b0;
      if (mst == 4'h0 || inten == led_pwm_pkg::INTENS_STATIC) begin
         // static output, no pwm glitches
         drive_low = ~lvl; // [R14] [R20]
      end else begin
         on_time = (slot < mst) && (cyc <= inten); // [R12] [R13] [R21]
         drive_low = on_time ? ~lvl : lvl; // [R15] [R16]
      end
   endfunction : drive_low

   function automatic logic is_intens_addr(input logic [7:0] a);
      is_intens_addr = (a >= led_pwm_pkg::ADDR_INTENS0) && (a <= led_pwm_pkg::ADDR_INTENS3);
   endfunction : is_intens_addr

   // ****************************************
   // time base
   // ****************************************
   assign pwm_run = (st_reg.master[7:4] != 4'h0); // [R10]

   pwm_timebase u_timebase (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(pwm_run),
      .cycle_idx(cycle_idx),
      .slot_idx(slot_idx)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic phase_sel;
      logic [3:0] ten;
      logic [1:0] pair;
      logic lvl;
      st_next = st_reg;
      phase_sel = st_reg.cfg[led_pwm_pkg::CFG_BLINK_EN] && st_reg.cfg[led_pwm_pkg::CFG_FLIP];
      ten = 4'h0;
      pair = reg_addr[1:0];
      lvl = 1'b0;

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            led_pwm_pkg::ADDR_PHASE0: st_next.phase0 = reg_wdata;
            led_pwm_pkg::ADDR_PHASE1: st_next.phase1 = reg_wdata;
            led_pwm_pkg::ADDR_DIR: st_next.dir = reg_wdata; // [R9]
            led_pwm_pkg::ADDR_MASTER: st_next.master = reg_wdata;
            led_pwm_pkg::ADDR_CONFIG: st_next.cfg = reg_wdata[5:0];
            default: begin
               if (is_intens_addr(reg_addr)) begin
                  st_next.intens[{pair, 1'b0}] = reg_wdata[3:0];
                  st_next.intens[{pair, 1'b1}] = reg_wdata[7:4];
               end
            end
         endcase
      end

      // register reads, answered one cycle later
      if (reg_rd) begin
         unique case (reg_addr)
            led_pwm_pkg::ADDR_INPUT: st_next.rdata = pin_sense_bits;
            led_pwm_pkg::ADDR_PHASE0: st_next.rdata = st_reg.phase0; // [R8]
            led_pwm_pkg::ADDR_PHASE1: st_next.rdata = st_reg.phase1; // [R8]
            led_pwm_pkg::ADDR_DIR: st_next.rdata = st_reg.dir; // [R9]
            led_pwm_pkg::ADDR_MASTER: st_next.rdata = st_reg.master;
            led_pwm_pkg::ADDR_CONFIG: st_next.rdata = {st_reg.status, 1'b0, st_reg.cfg}; // [R4] [R5]
            default: begin
               if (is_intens_addr(reg_addr)) begin
                  st_next.rdata = {st_reg.intens[{pair, 1'b1}], st_reg.intens[{pair, 1'b0}]};
               end else begin
                  st_next.rdata = 8'h00;
               end
            end
         endcase
      end

      // change status: a read of the input ports clears it, a new change wins
      st_next.status = change_event |
                       (st_reg.status & ~(reg_rd && reg_addr == led_pwm_pkg::ADDR_INPUT)); // [R4]

      // port drivers
      for (int i = 0; i < 8; i++) begin
         lvl = phase_sel ? st_reg.phase1[i] : st_reg.phase0[i]; // [R6]
         ten = st_reg.cfg[led_pwm_pkg::CFG_GLOBAL] ? st_reg.master[3:0]
                                                    : st_reg.intens[i]; // [R17] [R19]
         // input ports never driven; open drain only pulls low
         st_next.ports_oe[i] = ~st_reg.dir[i] &
                               drive_low(lvl, ten, st_reg.master[7:4], cycle_idx, slot_idx); // [R7] [R9]
      end

      // ninth pin
      if (st_reg.cfg[led_pwm_pkg::CFG_IRQ_EN]) begin
         st_next.gpo_oe = st_reg.status; // [R1] [R4]
      end else begin
         lvl = phase_sel ? st_reg.cfg[led_pwm_pkg::CFG_GPO1]
                         : st_reg.cfg[led_pwm_pkg::CFG_GPO0]; // [R2] [R3]
         st_next.gpo_oe = drive_low(lvl, st_reg.master[3:0], st_reg.master[7:4],
                                    cycle_idx, slot_idx); // [R17]
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg.phase0 <= led_pwm_pkg::RST_PHASE;
         st_reg.phase1 <= led_pwm_pkg::RST_PHASE;
         st_reg.dir <= led_pwm_pkg::RST_DIR;
         st_reg.master <= led_pwm_pkg::RST_MASTER;
         st_reg.cfg <= led_pwm_pkg::RST_CONFIG;
         st_reg.status <= 1'b0;
         st_reg.intens <= {8{led_pwm_pkg::RST_INTENS}};
         st_reg.rdata <= 8'h00;
         st_reg.ports_oe <= 8'h00;
         st_reg.gpo_oe <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign io_ports_oe = st_reg.ports_oe;
   assign irq_or_gpo_pin_oe = st_reg.gpo_oe;
   // open drain: the driven level is always low
   assign io_ports_out = 8'h00;
   assign irq_or_gpo_pin_out = 1'b0;

endmodule : led_port_blink_pwm_control

// *** testbench/led_port_chk.sv ***
// assertions on the led port block, bound to its top module
// assumes every register write arrives through the block's own port
`timescale 1ns/1ps
module led_port_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic change_event,
   input wire logic [7:0] pin_sense_bits,
   input wire logic [7:0] io_ports_out,
   input wire logic [7:0] io_ports_oe,
   input wire logic irq_or_gpo_pin_out,
   input wire logic irq_or_gpo_pin_oe
);
   // ****************************************
   // register mirrors
   // ****************************************
   logic [7:0] p0_reg;
   logic [7:0] p1_reg;
   logic [7:0] dir_reg;
   logic [7:0] mst_reg;
   logic [5:0] cfg_reg;
   logic sel;
   logic [7:0] port_exp;
   assign sel = cfg_reg[0] & cfg_reg[1];
   assign port_exp = ~dir_reg & ~(sel ? p1_reg : p0_reg);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         p0_reg <= led_pwm_pkg::RST_PHASE;
         p1_reg <= led_pwm_pkg::RST_PHASE;
         dir_reg <= led_pwm_pkg::RST_DIR;
         mst_reg <= led_pwm_pkg::RST_MASTER;
         cfg_reg <= led_pwm_pkg::RST_CONFIG;
      end else if (reg_wr) begin
         case (reg_addr)
            led_pwm_pkg::ADDR_PHASE0: p0_reg <= reg_wdata;
            led_pwm_pkg::ADDR_PHASE1: p1_reg <= reg_wdata;
            led_pwm_pkg::ADDR_DIR: dir_reg <= reg_wdata;
            led_pwm_pkg::ADDR_MASTER: mst_reg <= reg_wdata;
            led_pwm_pkg::ADDR_CONFIG: cfg_reg <= reg_wdata[5:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_out_const_low: assert property (io_ports_out == 8'h00 && !irq_or_gpo_pin_out)
      else $error("open-drain data not low");
   a_cfg_bit6_zero: assert property (reg_rd && reg_addr == led_pwm_pkg::ADDR_CONFIG |=>
      !reg_rdata[6]) else $error("config bit 6 read as one");
   a_dir_readback: assert property (reg_rd && reg_addr == led_pwm_pkg::ADDR_DIR |=>
      reg_rdata == $past(dir_reg)) else $error("direction read-back wrong");
   a_phase_readback: assert property (reg_rd && reg_addr == led_pwm_pkg::ADDR_PHASE1 |=>
      reg_rdata == $past(p1_reg)) else $error("phase 1 read-back wrong");
   a_input_sample: assert property (reg_rd && reg_addr == led_pwm_pkg::ADDR_INPUT |=>
      reg_rdata == $past(pin_sense_bits)) else $error("input levels read wrong");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_irq_follows: assert property ((change_event && cfg_reg[3] && !reg_wr) ##1 !reg_wr
      |-> ##1 irq_or_gpo_pin_oe) else $error("irq pin not pulled low after change");
   a_ports_static: assert property (!$past(reg_wr) && !$past(reg_wr, 2) &&
      mst_reg[7:4] == 4'h0 |-> io_ports_oe == port_exp) else $error("static port level wrong");
   a_ninth_static: assert property (!$past(reg_wr) && !$past(reg_wr, 2) &&
      mst_reg[7:4] == 4'h0 && !cfg_reg[3] |-> irq_or_gpo_pin_oe == !(sel ? cfg_reg[5] :
      cfg_reg[4])) else $error("ninth pin level wrong");
   c_change: cover property (change_event && cfg_reg[3]);
   c_blink: cover property (sel && io_ports_oe != 8'h00);
   c_pwm: cover property (mst_reg[7:4] != 4'h0 && io_ports_oe != 8'h00);
endmodule : led_port_chk
bind led_port_blink_pwm_control led_port_chk chk (.clk(clk), .sys_rst(sys_rst),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .change_event(change_event), .pin_sense_bits(pin_sense_bits),
   .io_ports_out(io_ports_out), .io_ports_oe(io_ports_oe),
   .irq_or_gpo_pin_out(irq_or_gpo_pin_out), .irq_or_gpo_pin_oe(irq_or_gpo_pin_oe));

// *** testbench/reg_host.sv ***
// host model issuing single register writes and reads
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/1ps
module reg_host (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // released lines show inverted values so stale data cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask : rd
endmodule : reg_host

// *** testbench/led_port_blink_pwm_control_bench.sv ***
// self-checking bench for the led port block
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
module led_port_blink_pwm_control_bench;
   logic clk;
   logic sys_rst;
   logic change_event;
   logic [7:0] pin_sense_bits;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] io_ports_oe;
   logic irq_oe;
   int num_errors = 0;
   int samples_checked = 0;
   led_port_blink_pwm_control dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .change_event(change_event), .pin_sense_bits(pin_sense_bits), .io_ports_out(),
      .io_ports_oe(io_ports_oe), .irq_or_gpo_pin_out(), .irq_or_gpo_pin_oe(irq_oe));
   reg_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      check(d, exp);
   endtask : rd_chk
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset_regs;
      logic [7:0] adr [8] = '{8'h01, 8'h03, 8'h09, 8'h0E, 8'h0F, 8'h10, 8'h13, 8'h05};
      logic [7:0] val [8] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0C, 8'hFF, 8'hFF, 8'h00};
      for (int i = 0; i < 8; i++) begin
         rd_chk(adr[i], val[i]);
      end
   endtask : t_reset_regs
   task automatic t_status;
      @(posedge clk);
      change_event <= 1'b1;
      pin_sense_bits <= 8'hA5;
      @(posedge clk);
      change_event <= 1'b0;
      settle(2);
      check({7'h00, irq_oe}, 8'h01);
      rd_chk(8'h0F, 8'h8C);
      rd_chk(8'h00, 8'hA5);
      rd_chk(8'h0F, 8'h0C);
      host.wr(8'h0F, 8'hFF);
      rd_chk(8'h0F, 8'h3F);
   endtask : t_status
   task automatic t_ports;
      host.wr(8'h03, 8'h00);
      host.wr(8'h01, 8'h5A);
      host.wr(8'h09, 8'h3C);
      host.wr(8'h0F, 8'h00);
      settle(3);
      check(io_ports_oe, 8'hA5);
      check({7'h00, irq_oe}, 8'h01);
      host.wr(8'h0F, 8'h23);
      settle(3);
      check(io_ports_oe, 8'hC3);
      check({7'h00, irq_oe}, 8'h00);
      host.wr(8'h0F, 8'h21);
      settle(3);
      check(io_ports_oe, 8'hA5);
      check({7'h00, irq_oe}, 8'h01);
      rd_chk(8'h01, 8'h5A);
      rd_chk(8'h09, 8'h3C);
      rd_chk(8'h03, 8'h00);
   endtask : t_ports
   // one master slot, global nibble 1: on for the first two pwm cycles
   task automatic t_pwm;
      host.wr(8'h0F, 8'h04);
      host.wr(8'h0E, 8'h11);
      settle(3000);
      check(io_ports_oe, 8'hA5);
      check({7'h00, irq_oe}, 8'h01);
      settle(3500);
      check(io_ports_oe, 8'h5A);
      check({7'h00, irq_oe}, 8'h00);
      host.wr(8'h0E, 8'h1F);
      settle(6600);
      check(io_ports_oe, 8'hA5);
      // global nibble 1 would pulse if the zero master nibble did not force static
      host.wr(8'h0E, 8'h01);
      settle(3);
      check(io_ports_oe, 8'hA5);
      check({7'h00, irq_oe}, 8'h01);
   endtask : t_pwm
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      sys_rst = 1'b1;
      change_event = 1'b0;
      pin_sense_bits = 8'h00;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset_regs();
      t_status();
      t_ports();
      t_pwm();
      test_done();
   end
   // run needs about 13k cycles
   initial begin
      #300000;
      num_errors++;
      test_done();
   end
endmodule : led_port_blink_pwm_control_bench
